// ---- hdl/ept_pkg.sv ----
// ept_pkg: widths and timing for the 1k x 8 eprom programmer/reader.
// assumes a 100 MHz system clock; all cycle counts derive from it.
package ept_pkg;

  // ==========================================================
  // array geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int WORDS  = 1024;

  // ==========================================================
  // clock and times in their own units
  localparam int CLK_PERIOD_NS   = 10;
  localparam int T_PULSE_NS      = 1000000;  // longest pulse, 1.0 ms
  localparam int T_PULSE_MIN_NS  = 100000;   // shortest pulse, 0.1 ms
  localparam int T_GAP_NS        = 1000;     // after pulse, before address step
  localparam int T_SETUP_NS      = 10000;    // address/data/enable setup
  localparam int T_ACCESS_NS     = 450;      // read access time
  localparam int T_RECOVER_NS    = 10000;    // outputs invalid after exit
  localparam int T_PROG_TOTAL_MS = 100;      // loops x pulse width
  localparam int SYNC_STAGES     = 2;

  // ==========================================================
  // derived cycle counts (least times round up, longest down)
  localparam int PULSE_CYC     = T_PULSE_NS / CLK_PERIOD_NS;
  localparam int PULSE_MIN_CYC = (T_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC       = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC     = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC    = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC   = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC      = ACCESS_CYC + SYNC_STAGES;
  localparam int PROG_LOOPS    = (T_PROG_TOTAL_MS * 1000000 + T_PULSE_NS - 1) / T_PULSE_NS;

  localparam int TMR_W  = 17;
  localparam int LOOP_W = 16;

  // ==========================================================
  // sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_READ  = 6'h02,
    ST_SETUP = 6'h04,
    ST_PULSE = 6'h08,
    ST_GAP   = 6'h10,
    ST_RECOV = 6'h20
  } ept_state_type;

endpackage : ept_pkg

// ---- hdl/ept_programmer.sv ----
// ept_programmer: host controller that reads and programs a 1k x 8 uv eprom
// through its address, data, select/program-enable and program pins.
// assumes external level shifters turn the enable flags into +12 V / +25 V.
// Functional notes
// - program pin stays low whenever not programming.
// - raise select to +12 V for whole program sequence; data lines become inputs.
// - address and data applied before each +25 V program pulse.
// - program pulse lasts 0.1 to 1.0 ms, then back to 0 V.
// - wait at least 1 us after pulse before next address.
// - every word pulsed once per loop; loops times pulse reach 100 ms.
// - exit by ending last pulse, then dropping select to low.
// - release data lines before changing address after exit.
`timescale 1ns/1ps
module ept_programmer #(
  parameter int PULSE_CYC     = ept_pkg::PULSE_CYC,
  parameter int LOOPS         = ept_pkg::PROG_LOOPS,
  parameter int SETUP_CYC     = ept_pkg::SETUP_CYC,
  parameter int GAP_CYC       = ept_pkg::GAP_CYC,
  parameter int PULSE_MIN_CYC = ept_pkg::PULSE_MIN_CYC
) (
  input  wire logic                      i_sys_clk,                   // 100 MHz clock
  input  wire logic                      i_nrst,                      // sync reset, active low
  input  wire logic                      i_load_we,                   // image write strobe
  input  wire logic [ept_pkg::ADDR_W-1:0] i_load_addr,                // image write address
  input  wire logic [ept_pkg::DATA_W-1:0] i_load_data,                // image write data
  input  wire logic                      i_prog_start,                // start programming
  input  wire logic                      i_rd_req,                    // read request
  input  wire logic [ept_pkg::ADDR_W-1:0] i_rd_addr,                  // read address
  output logic                           o_ready,                     // idle, accepts request
  output logic                           o_busy,                      // sequence running
  output logic                           o_prog_done,                 // programming finished
  output logic                           o_rd_valid,                  // read data strobe
  output logic [ept_pkg::DATA_W-1:0]     o_rd_data,                   // read data
  output logic [ept_pkg::ADDR_W-1:0]     o_word_address_lines,        // device address pins
  input  wire logic [ept_pkg::DATA_W-1:0] i_data_io_lines,            // data pins, in
  output logic [ept_pkg::DATA_W-1:0]     o_data_io_lines,             // data pins, out
  output logic                           o_data_io_lines_oe,          // data pins driven
  output logic                           o_select_program_enable,     // select level, 1 = high
  output logic                           o_select_program_enable_hv,  // select at +12 V
  output logic                           o_program_pulse              // program pin at +25 V
);

  localparam int AW = ept_pkg::ADDR_W;
  localparam int DW = ept_pkg::DATA_W;
  localparam int TW = ept_pkg::TMR_W;
  localparam int LW = ept_pkg::LOOP_W;

  // ==========================================================
  // helpers
  function automatic logic [TW-1:0] cyc_len(input int n);
    cyc_len = TW'(n - 1);
  endfunction : cyc_len

  function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v);
    sat_inc = (v == '1) ? v : v + TW'(1);
  endfunction : sat_inc

  // ==========================================================
  // image memory and pin synchroniser
  logic [DW-1:0] img_mem [ept_pkg::WORDS];
  logic [DW-1:0] din_meta_q;
  logic [DW-1:0] din_sync_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_load_we) begin
      img_mem[i_load_addr] <= i_load_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      din_meta_q <= '1;
      din_sync_q <= '1;
    end else begin
      din_meta_q <= i_data_io_lines;
      din_sync_q <= din_meta_q;
    end
  end

  // ==========================================================
  // sequencer
  ept_pkg::ept_state_type state_q;
  ept_pkg::ept_state_type state_d;
  logic                   tmr_load;
  logic [TW-1:0]          tmr_count;
  logic                   tmr_zero;
  logic [AW-1:0]          addr_q;
  logic [LW-1:0]          loop_q;
  logic                   last_word;
  logic                   last_loop;

  assign last_word = (addr_q == AW'(ept_pkg::WORDS - 1));
  assign last_loop = (loop_q == LW'(LOOPS - 1));

  ept_timer #(.W(TW)) u_timer (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_load    (tmr_load),
    .i_count   (tmr_count),
    .o_zero    (tmr_zero)
  );

  always_comb begin
    state_d   = state_q;
    tmr_load  = 1'b0;
    tmr_count = '0;
    unique case (state_q)
      ept_pkg::ST_IDLE: begin
        if (i_prog_start) begin
          state_d   = ept_pkg::ST_SETUP;
          tmr_load  = 1'b1;
          tmr_count = cyc_len(SETUP_CYC);
        end else if (i_rd_req) begin
          state_d   = ept_pkg::ST_READ;
          tmr_load  = 1'b1;
          tmr_count = cyc_len(ept_pkg::READ_CYC);
        end
      end
      ept_pkg::ST_READ: begin
        if (tmr_zero) begin
          state_d = ept_pkg::ST_IDLE;
        end
      end
      ept_pkg::ST_SETUP: begin
        if (tmr_zero) begin
          state_d   = ept_pkg::ST_PULSE;
          tmr_load  = 1'b1;
          tmr_count = cyc_len(PULSE_CYC);
        end
      end
      ept_pkg::ST_PULSE: begin
        if (tmr_zero) begin
          state_d   = ept_pkg::ST_GAP;
          tmr_load  = 1'b1;
          tmr_count = cyc_len(GAP_CYC);
        end
      end
      ept_pkg::ST_GAP: begin
        if (tmr_zero) begin
          tmr_load = 1'b1;
          if (last_word && last_loop) begin
            state_d   = ept_pkg::ST_RECOV;
            tmr_count = cyc_len(ept_pkg::RECOVER_CYC);
          end else begin
            state_d   = ept_pkg::ST_SETUP;
            tmr_count = cyc_len(SETUP_CYC);
          end
        end
      end
      ept_pkg::ST_RECOV: begin
        if (tmr_zero) begin
          state_d = ept_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = ept_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      state_q <= ept_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // address walk and loop count
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      addr_q <= '0;
      loop_q <= '0;
    end else if (state_q == ept_pkg::ST_IDLE && i_prog_start) begin
      addr_q <= '0;
      loop_q <= '0;
    end else if (state_q == ept_pkg::ST_IDLE && i_rd_req) begin
      addr_q <= i_rd_addr;
    end else if (state_q == ept_pkg::ST_GAP && state_d == ept_pkg::ST_SETUP) begin
      addr_q <= addr_q + AW'(1);
      if (last_word) begin
        loop_q <= loop_q + LW'(1);
      end
    end
  end

  // program data follows the word being set up
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_data_io_lines <= '1;
    end else if (state_d == ept_pkg::ST_SETUP && state_q != ept_pkg::ST_SETUP) begin
      if (state_q == ept_pkg::ST_IDLE) begin
        o_data_io_lines <= img_mem[0];
      end else begin
        o_data_io_lines <= img_mem[addr_q + AW'(1)];
      end
    end
  end

  // pin levels
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_select_program_enable_hv <= 1'b0;
      o_data_io_lines_oe         <= 1'b0;
      o_program_pulse            <= 1'b0;
      o_select_program_enable    <= 1'b1;
    end else begin
      o_select_program_enable_hv <= (state_d == ept_pkg::ST_SETUP) || (state_d == ept_pkg::ST_PULSE)
                                    || (state_d == ept_pkg::ST_GAP);
      o_data_io_lines_oe         <= (state_d == ept_pkg::ST_SETUP) || (state_d == ept_pkg::ST_PULSE)
                                    || (state_d == ept_pkg::ST_GAP);
      o_program_pulse            <= (state_d == ept_pkg::ST_PULSE);
      o_select_program_enable    <= !((state_d == ept_pkg::ST_READ)
                                    || (state_d == ept_pkg::ST_RECOV));
    end
  end

  assign o_word_address_lines = addr_q;

  // read capture after access plus synchroniser delay
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_rd_valid  <= 1'b0;
      o_rd_data   <= '0;
      o_prog_done <= 1'b0;
    end else begin
      o_rd_valid  <= (state_q == ept_pkg::ST_READ) && tmr_zero;
      o_prog_done <= (state_q == ept_pkg::ST_RECOV) && tmr_zero;
      if ((state_q == ept_pkg::ST_READ) && tmr_zero) begin
        o_rd_data <= din_sync_q;
      end
    end
  end

  assign o_ready = (state_q == ept_pkg::ST_IDLE);
  assign o_busy  = (state_q != ept_pkg::ST_IDLE);

  // ==========================================================
  // checks
  localparam int CHK_READ  = ept_pkg::READ_CYC - 1;
  localparam int CHK_GAP   = GAP_CYC;
  localparam int CHK_SETUP = SETUP_CYC - 1;  // stable count lags the pins by one edge
  localparam int CHK_REC   = ept_pkg::RECOVER_CYC;
  localparam int CHK_PMIN  = PULSE_MIN_CYC;

  logic [TW-1:0] pulse_len_q;
  logic [TW-1:0] since_pulse_q;
  logic [TW-1:0] since_exit_q;
  logic [TW-1:0] sel_low_q;
  logic [TW-1:0] stable_q;
  logic [AW-1:0] prev_addr_q;
  logic [DW-1:0] prev_data_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      pulse_len_q   <= '0;
      since_pulse_q <= '1;
      since_exit_q  <= '1;
      sel_low_q     <= '0;
      stable_q      <= '0;
      prev_addr_q   <= '0;
      prev_data_q   <= '0;
    end else begin
      pulse_len_q   <= o_program_pulse ? sat_inc(pulse_len_q) : '0;
      since_pulse_q <= o_program_pulse ? '0 : sat_inc(since_pulse_q);
      since_exit_q  <= o_select_program_enable_hv ? '0 : sat_inc(since_exit_q);
      sel_low_q     <= o_select_program_enable ? '0 : sat_inc(sel_low_q);
      prev_addr_q   <= o_word_address_lines;
      prev_data_q   <= o_data_io_lines;
      stable_q      <= (!o_select_program_enable_hv || prev_addr_q != o_word_address_lines
                        || prev_data_q != o_data_io_lines) ? '0 : sat_inc(stable_q);
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  property p_pulse_in_prog;
    o_program_pulse |-> o_select_program_enable_hv && o_data_io_lines_oe;
  endproperty
  a_pulse_in_prog: assert property (p_pulse_in_prog) else $error("pulse outside program mode");

  property p_pulse_width;
    $fell(o_program_pulse) |-> pulse_len_q == TW'(PULSE_CYC) && pulse_len_q >= TW'(CHK_PMIN);
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("program pulse width wrong");

  property p_setup;
    $rose(o_program_pulse) |-> stable_q >= TW'(CHK_SETUP);
  endproperty
  a_setup: assert property (p_setup) else $error("address or data not set up before pulse");

  property p_gap;
    o_select_program_enable_hv && (o_word_address_lines != prev_addr_q) |-> since_pulse_q >= TW'(CHK_GAP);
  endproperty
  a_gap: assert property (p_gap) else $error("address stepped too soon after pulse");

  property p_no_pulse_read;
    !o_select_program_enable_hv |-> !o_program_pulse && !o_data_io_lines_oe;
  endproperty
  a_no_pulse_read: assert property (p_no_pulse_read) else $error("pulse or drive in read mode");

  property p_exit;
    $fell(o_select_program_enable_hv) |-> !o_program_pulse && !o_data_io_lines_oe
      && !o_select_program_enable && $stable(o_word_address_lines) ##1 !o_select_program_enable;
  endproperty
  a_exit: assert property (p_exit) else $error("bad program mode exit");

  property p_start_zero;
    $rose(o_select_program_enable_hv) |-> o_word_address_lines == '0 && loop_q == '0;
  endproperty
  a_start_zero: assert property (p_start_zero) else $error("loop not started at address zero");

  property p_recover;
    o_rd_valid |-> since_exit_q >= TW'(CHK_REC);
  endproperty
  a_recover: assert property (p_recover) else $error("read sampled during recovery");

  property p_read_access;
    o_rd_valid |-> $past(sel_low_q) == TW'(CHK_READ) && $stable(o_word_address_lines);
  endproperty
  a_read_access: assert property (p_read_access) else $error("read sampled before access time");

  property p_loops;
    o_prog_done |-> loop_q == LW'(LOOPS - 1) && o_word_address_lines == AW'(ept_pkg::WORDS - 1);
  endproperty
  a_loops: assert property (p_loops) else $error("programming ended early");

endmodule : ept_programmer

// ---- hdl/ept_timer.sv ----
// ept_timer: loadable down counter for sequencer phase lengths.
// assumes the loader holds i_load for one cycle with length-1.
`timescale 1ns/1ps
module ept_timer #(
  parameter int W = 17
) (
  input  wire logic         i_sys_clk,  // system clock
  input  wire logic         i_nrst,     // sync reset, active low
  input  wire logic         i_load,     // load pulse
  input  wire logic [W-1:0] i_count,    // value to load
  output logic              o_zero      // count has run out
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      cnt_q <= '0;
    end else if (i_load) begin
      cnt_q <= i_count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign o_zero = (cnt_q == '0);

endmodule : ept_timer

// ---- verif/eprom_1k8_read_program_port_tb.sv ----
// eprom_1k8_read_program_port_tb: self-checking bench for ept_programmer.
// assumes ept_dev_model on the pins; setup, pulse, gap and loop counts shortened for run time.
`timescale 1ns/1ps
module eprom_1k8_read_program_port_tb;
  localparam int PCYC  = 20;
  localparam int NLOOP = 2;
  localparam int SCYC  = 4;
  localparam int GCYC  = 2;
  localparam int PMIN  = 10;
  localparam int AW    = ept_pkg::ADDR_W;
  logic          i_sys_clk, i_nrst, i_load_we, i_prog_start, i_rd_req;
  logic [AW-1:0] i_load_addr, i_rd_addr, addr;
  logic [7:0]    i_load_data, dq_wire, dq_last, dev_q, data_o, rd_data;
  logic          ready, busy, done, rd_valid, oe, sel, hv, pgm, dev_oe;
  logic [7:0]    img [ept_pkg::WORDS];
  logic [7:0]    exp_q [$];
  int            fail_count, n_tests, seed, n_pulse, n_done, width, gap, exp_addr;
  int            bad5, bad8, bad9, bad10, bad11, bad13, bad14;
  logic          pgm_p, hv_p;
  logic [AW-1:0] addr_p;
  logic [7:0]    data_p;

  ept_programmer #(.PULSE_CYC(PCYC), .LOOPS(NLOOP), .SETUP_CYC(SCYC), .GAP_CYC(GCYC), .PULSE_MIN_CYC(PMIN)) uut (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_load_we(i_load_we), .i_load_addr(i_load_addr),
    .i_load_data(i_load_data), .i_prog_start(i_prog_start), .i_rd_req(i_rd_req), .i_rd_addr(i_rd_addr),
    .o_ready(ready), .o_busy(busy), .o_prog_done(done), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
    .o_word_address_lines(addr), .i_data_io_lines(dq_wire), .o_data_io_lines(data_o),
    .o_data_io_lines_oe(oe), .o_select_program_enable(sel), .o_select_program_enable_hv(hv),
    .o_program_pulse(pgm));
  ept_dev_model dev (.i_sys_clk(i_sys_clk), .i_addr(addr), .i_sel(sel), .i_sel_hv(hv), .i_pgm(pgm),
    .i_dq(dq_wire), .o_dq(dev_q), .o_dq_oe(dev_oe));

  // released wire shows a toggling pattern
  assign dq_wire = oe ? data_o : (dev_oe ? dev_q : ~dq_last);

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic wait_ready();
    int k;
    k = 0;
    @(negedge i_sys_clk);
    while (ready !== 1'b1 && k < 3000000) begin
      @(negedge i_sys_clk);
      k++;
    end
    @(posedge i_sys_clk);
  endtask : wait_ready

  task automatic rd(input logic [AW-1:0] a, input logic [7:0] e);
    wait_ready();
    i_rd_req  <= 1'b1;
    i_rd_addr <= a;
    exp_q.push_back(e);
    @(posedge i_sys_clk);
    i_rd_req <= 1'b0;
  endtask : rd

  // ==========================================================
  // pin watcher
  always @(posedge i_sys_clk) begin
    dq_last <= dq_wire;
    pgm_p   <= pgm;
    hv_p    <= hv;
    addr_p  <= addr;
    data_p  <= data_o;
    if (i_nrst) begin
      if (pgm && !hv) bad5++;
      if (hv && !oe) bad8++;
      if (oe && dev_oe) bad14++;
      if (oe && !hv && addr !== addr_p) bad14++;
      if (pgm && !pgm_p) begin
        n_pulse++;
        if (addr !== AW'(exp_addr) || data_o !== img[addr]) bad9++;
        exp_addr++;
        width = 0;
      end
      if (pgm) begin
        width++;
        if (addr !== addr_p || data_o !== data_p) bad9++;
      end
      if (!pgm && pgm_p) begin
        if (width != PCYC) bad10++;
        gap = 0;
      end else if (!pgm) gap++;
      if (hv && addr !== addr_p && gap < GCYC) bad11++;
      if (!hv && hv_p && (pgm_p || pgm || sel !== 1'b0)) bad13++;
      if (done === 1'b1) n_done++;
    end
  end

  // read result monitor
  always @(posedge i_sys_clk) begin
    if (i_nrst && rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check("rd_extra", 1, 0);
      else check("rd_data", rd_data, exp_q.pop_front());
    end
  end

  // limit: every word of every loop plus loads, reads and recovery, with margin
  initial begin
    #(10 * (ept_pkg::WORDS * NLOOP * (SCYC + PCYC + GCYC) + 20000));
    fail_count++;
    finish_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    seed = 32'ha14a;
    {i_nrst, i_load_we, i_prog_start, i_rd_req} = 4'h0;
    {i_load_addr, i_rd_addr, i_load_data} = '0;
    {fail_count, n_tests, n_pulse, n_done, width, exp_addr} = '0;
    {bad5, bad8, bad9, bad10, bad11, bad13, bad14} = '0;
    gap = 1000000;
    dq_last = 8'h00;
    repeat (6) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    @(posedge i_sys_clk);
    #1;
    check("oe", oe, 0);
    check("hv", hv, 0);
    check("pgm", pgm, 0);
    check("sel", sel, 1);
    check("dev_oe", dev_oe, 0);
    check("busy", {ready, busy}, 2'b10);
    $display("test reset done");

    rd(10'h000, 8'hff);
    rd(10'h3ff, 8'hff);
    for (int i = 0; i < 6; i++) rd(AW'($random(seed)), 8'hff);
    wait_ready();
    $display("test erased read done");

    for (int i = 0; i < ept_pkg::WORDS; i++) begin
      img[i] = (i == 0) ? 8'h00 : ((i == 1023) ? 8'hff : 8'($random(seed)));
      i_load_we   <= 1'b1;
      i_load_addr <= AW'(i);
      i_load_data <= img[i];
      @(posedge i_sys_clk);
    end
    i_load_we <= 1'b0;
    wait_ready();
    i_prog_start <= 1'b1;
    @(posedge i_sys_clk);
    i_prog_start <= 1'b0;
    repeat (50) @(posedge i_sys_clk);
    i_rd_req     <= 1'b1;
    i_prog_start <= 1'b1;
    @(posedge i_sys_clk);
    i_rd_req     <= 1'b0;
    i_prog_start <= 1'b0;
    wait_ready();
    #1;
    check("sel_after", sel, 1);
    check("n_done", n_done, 1);
    check("n_pulse", n_pulse, ept_pkg::WORDS * NLOOP);
    check("bad5", bad5, 0);
    check("bad8", bad8, 0);
    check("bad9", bad9, 0);
    check("bad10", bad10, 0);
    check("bad11", bad11, 0);
    check("bad13", bad13, 0);
    $display("test program done");

    rd(10'h3ff, img[1023]);
    rd(10'h000, img[0]);
    for (int i = 0; i < 32; i++) begin
      rd(AW'(i * 37 + 5), img[(i * 37 + 5) % ept_pkg::WORDS]);
    end
    wait_ready();
    repeat (2) @(posedge i_sys_clk);
    check("rd_left", exp_q.size(), 0);
    check("bad14", bad14, 0);
    $display("test readback done");
    finish_test();
  end
endmodule : eprom_1k8_read_program_port_tb

// ---- verif/ept_dev_model.sv ----
// ept_dev_model: behavioural 1k x 8 uv eprom as seen from its pins.
// assumes pins are sampled on the host clock; voltage levels arrive as flags.
`timescale 1ns/1ps
module ept_dev_model (
  input  wire logic                       i_sys_clk,  // sampling clock
  input  wire logic [ept_pkg::ADDR_W-1:0] i_addr,     // word address pins
  input  wire logic                       i_sel,      // select level, 1 = high
  input  wire logic                       i_sel_hv,   // select at +12 V
  input  wire logic                       i_pgm,      // program pin at +25 V
  input  wire logic [ept_pkg::DATA_W-1:0] i_dq,       // resolved data wire
  output logic      [ept_pkg::DATA_W-1:0] o_dq,       // data driven
  output logic                            o_dq_oe     // data driver on
);
  logic [ept_pkg::DATA_W-1:0] mem_q [ept_pkg::WORDS];
  logic [ept_pkg::ADDR_W-1:0] addr_q;
  logic                       sel_q;
  logic                       hv_q;
  logic                       pgm_q;
  int                         wait_q;

  // ==========================================================
  // array and timing state
  initial begin
    for (int i = 0; i < ept_pkg::WORDS; i++) mem_q[i] = 8'hff;
    addr_q = '0;
    sel_q  = 1'b1;
    hv_q   = 1'b0;
    pgm_q  = 1'b0;
    wait_q = 0;
  end

  always @(posedge i_sys_clk) begin
    addr_q <= i_addr;
    sel_q  <= i_sel;
    hv_q   <= i_sel_hv;
    pgm_q  <= i_pgm;
    if (i_sel_hv && i_pgm && !pgm_q) mem_q[i_addr] <= mem_q[i_addr] & i_dq;
    if (hv_q && !i_sel_hv) wait_q <= ept_pkg::RECOVER_CYC;
    else if (i_addr != addr_q || (sel_q && !i_sel)) wait_q <= ept_pkg::ACCESS_CYC - 2;
    else if (wait_q > 0) wait_q <= wait_q - 1;
  end

  // ==========================================================
  // outputs: garbage until access or recovery time has run out
  assign o_dq_oe = !i_sel && !i_sel_hv;
  assign o_dq    = (wait_q == 0) ? mem_q[i_addr] : ~mem_q[i_addr];
endmodule : ept_dev_model
